//--- src/corca_pkg.sv
// shared constants of the or / rotate-through-carry core slice
package corca_pkg;
  // instruction word fields
  localparam int OPC_HI      = 31;
  localparam int OPC_LO      = 26;
  localparam int ZEFF_BIT    = 25;
  localparam int CEFF_BIT    = 24;
  localparam int WR_BIT      = 23;
  localparam int IMM_BIT     = 22;
  localparam int COND_HI     = 21;
  localparam int COND_LO     = 18;
  localparam int DST_HI      = 17;
  localparam int DST_LO      = 9;
  localparam int SRC_HI      = 8;
  localparam int SRC_LO      = 0;
  localparam int CNT_W       = 5;
  // opcodes
  localparam logic [5:0] OPC_OR   = 6'h1A;
  localparam logic [5:0] OPC_RCL  = 6'h0D;
  localparam logic [5:0] OPC_RCR  = 6'h0C;
  // core ram and timing
  localparam int RAM_DEPTH    = 496;
  localparam logic [8:0] LAUNCH_ADDR = 9'h000;
  localparam int CLKS_PER_INSTR = 4;
  // bus map, byte addresses
  localparam logic [11:0] ADR_CTRL   = 12'h800;
  localparam logic [11:0] ADR_STATUS = 12'h804;
  localparam logic [11:0] ADR_PC     = 12'h808;
  localparam int ADR_RAM_SEL  = 11;
  localparam int CTRL_LAUNCH  = 0;
  localparam int CTRL_STOP    = 1;
  localparam int STAT_RUN     = 0;
  localparam int STAT_Z       = 1;
  localparam int STAT_C       = 2;
  localparam logic RUN_RST    = 1'b0;
  localparam logic FLAG_RST   = 1'b0;
endpackage

//--- src/corca_alu_if.sv
// operand and result bundle between core sequencer and alu
`timescale 1ns/1ps
`default_nettype none
interface corca_alu_if;
  logic [5:0]  op;
  logic [31:0] dst_val;
  logic [31:0] src_val;
  logic        c_in;
  logic [31:0] result;
  logic        z_out;
  logic        c_out;
  logic        known;
  modport core (output op, output dst_val, output src_val, output c_in,
                input result, input z_out, input c_out, input known);
  modport alu  (input op, input dst_val, input src_val, input c_in,
                output result, output z_out, output c_out, output known);
endinterface
`default_nettype wire

//--- src/corca_alu.sv
// combinational or / rotate-through-carry alu
`timescale 1ns/1ps
`default_nettype none
module corca_alu
(
  // operands and results
  corca_alu_if.alu a
);
  logic [4:0]  cnt;
  logic [63:0] lft;
  logic [63:0] rgt;

  assign cnt = a.src_val[corca_pkg::CNT_W-1:0]; // [RQ13]
  assign lft = {a.dst_val, {32{a.c_in}}} << cnt; // [RQ6]
  assign rgt = {{32{a.c_in}}, a.dst_val} >> cnt; // [RQ9]

  always_comb
  begin
    a.result = a.dst_val;
    a.c_out  = a.c_in;
    a.known  = 1'b1;
    unique case (a.op)
      corca_pkg::OPC_OR:
      begin
        a.result = a.dst_val | a.src_val; // [RQ1]
        a.c_out  = ^(a.dst_val | a.src_val); // [RQ2]
      end
      corca_pkg::OPC_RCL:
      begin
        a.result = lft[63:32]; // [RQ6]
        a.c_out  = a.dst_val[31]; // [RQ8]
      end
      corca_pkg::OPC_RCR:
      begin
        a.result = rgt[31:0]; // [RQ9]
        a.c_out  = a.dst_val[0]; // [RQ11]
      end
      default:
        a.known  = 1'b0;
    endcase
  end

  assign a.z_out = (a.result == 32'h0000_0000); // [RQ2] [RQ6] [RQ9]
endmodule
`default_nettype wire

//--- src/corca_top.sv
// core slice: local ram, four-clock sequencer, flags and wishbone slave
// Behaviour
// RQ1 - opcode 011010 ORs destination and source into the destination unless no-write is set, in 4 clocks.
// RQ2 - with the zero effect OR sets Z on a zero result, with the carry effect C takes the result's odd parity.
// RQ3 - the second OR operand is a register or, with the immediate bit, a 9-bit literal zero-extended.
// RQ4 - a launched core fetches and executes its first instruction from ram address 0.
// RQ5 - local ram holds code at addresses 0 through 495.
// RQ6 - opcode 001101 rotates the destination left, filling low bits with the original C, Z on zero, 4 clocks.
// RQ7 - the left rotate count comes from a register or a 5-bit immediate.
// RQ8 - with the carry effect the left rotate loads C with original bit 31, result written unless no-write.
// RQ9 - opcode 001100 rotates the destination right, filling high bits with the original C, Z on zero, 4 clocks.
// RQ10 - the right rotate count comes from a register or a 5-bit immediate.
// RQ11 - with the carry effect the right rotate loads C with original bit 0, result written unless no-write.
// RQ12 - the word splits into opcode, zero, carry, write, immediate bits, 4-bit condition, 9-bit dest and source.
// RQ13 - a register rotate count uses only its low five bits, giving 0 to 31.
//
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module corca_top
(
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [11:0] WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O
);
  typedef enum logic [1:0] {S_FETCH, S_OPER, S_EXEC, S_WRITE} corca_state_t;

  corca_state_t st_r;
  logic [31:0]  ram [corca_pkg::RAM_DEPTH];
  logic [8:0]   pc_r;
  logic         run_r;
  logic         stop_r;
  logic         z_r;
  logic         c_r;
  logic [31:0]  ir_r;
  logic [31:0]  d_r;
  logic [31:0]  s_r;
  logic [31:0]  res_r;
  logic         zn_r;
  logic         cn_r;
  logic         known_r;
  logic         ack_r;
  logic [31:0]  rdat_r;
  logic         bus_req;
  logic         bus_wr;
  logic         launch_w;
  logic         stop_w;
  logic         ram_hit;
  logic [8:0]   bus_idx;
  logic [31:0]  wmask;
  logic         exec_ok;
  logic [5:0]   opc;
  logic [8:0]   dst_f;
  logic [8:0]   src_f;
  logic         is_rot;

  corca_alu_if alu_bus ();

  corca_alu u_alu
  (
    .a (alu_bus.alu)
  );

  // instruction fields [RQ12]
  assign opc    = ir_r[corca_pkg::OPC_HI:corca_pkg::OPC_LO];
  assign dst_f  = ir_r[corca_pkg::DST_HI:corca_pkg::DST_LO];
  assign src_f  = ir_r[corca_pkg::SRC_HI:corca_pkg::SRC_LO];
  assign is_rot = (opc == corca_pkg::OPC_RCL) || (opc == corca_pkg::OPC_RCR);
  // condition: bit {C,Z} of the field, all ones always runs [RQ12]
  assign exec_ok = ir_r[corca_pkg::COND_LO + {30'h0000_0000, c_r, z_r}];

  assign alu_bus.op      = opc;
  assign alu_bus.dst_val = d_r;
  assign alu_bus.src_val = s_r;
  assign alu_bus.c_in    = c_r;

  // bus decode
  assign bus_req  = WB_CYC_I && WB_STB_I;
  assign bus_wr   = bus_req && WB_WE_I && ack_r;
  assign bus_idx  = WB_ADR_I[10:2];
  assign ram_hit  = !WB_ADR_I[corca_pkg::ADR_RAM_SEL] && (bus_idx < 9'(corca_pkg::RAM_DEPTH)); // [RQ5]
  assign launch_w = bus_wr && (WB_ADR_I == corca_pkg::ADR_CTRL) && WB_SEL_I[0]
                    && WB_DAT_I[corca_pkg::CTRL_LAUNCH];
  assign stop_w   = bus_wr && (WB_ADR_I == corca_pkg::ADR_CTRL) && WB_SEL_I[0]
                    && WB_DAT_I[corca_pkg::CTRL_STOP];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_mask
      assign wmask[gi*8 +: 8] = {8{WB_SEL_I[gi]}};
    end
  endgenerate

  // sequencer: fetch, operands, execute, write back [RQ1] [RQ6] [RQ9]
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st_r  <= S_FETCH;
      run_r <= corca_pkg::RUN_RST;
      pc_r  <= 9'h000;
    end
    else if (launch_w)
    begin
      st_r  <= S_FETCH;
      run_r <= 1'b1;
      pc_r  <= corca_pkg::LAUNCH_ADDR; // [RQ4]
    end
    else if (run_r)
    begin
      unique case (st_r)
        S_FETCH: st_r <= S_OPER;
        S_OPER:  st_r <= S_EXEC;
        S_EXEC:  st_r <= S_WRITE;
        S_WRITE:
        begin
          st_r  <= S_FETCH;
          run_r <= !stop_r;
          pc_r  <= (pc_r == 9'(corca_pkg::RAM_DEPTH - 1)) ? 9'h000 : pc_r + 9'h001; // [RQ5]
        end
      endcase
    end
  end

  // stop request, a new request wins over the clear
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      stop_r <= 1'b0;
    else if (stop_w)
      stop_r <= 1'b1;
    else if (launch_w || (run_r && st_r == S_WRITE))
      stop_r <= 1'b0;
  end

  // instruction and operand registers
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ir_r <= 32'h0000_0000;
      d_r  <= 32'h0000_0000;
      s_r  <= 32'h0000_0000;
    end
    else if (run_r && !launch_w)
    begin
      if (st_r == S_FETCH)
        ir_r <= ram[pc_r]; // [RQ4]
      if (st_r == S_OPER)
      begin
        d_r <= (dst_f < 9'(corca_pkg::RAM_DEPTH)) ? ram[dst_f] : 32'h0000_0000;
        if (ir_r[corca_pkg::IMM_BIT])
          s_r <= {23'h00_0000, src_f}; // [RQ3] [RQ7] [RQ10]
        else if (src_f >= 9'(corca_pkg::RAM_DEPTH))
          s_r <= 32'h0000_0000;
        else if (is_rot)
          s_r <= {27'h000_0000, ram[src_f][corca_pkg::CNT_W-1:0]}; // [RQ13]
        else
          s_r <= ram[src_f]; // [RQ3]
      end
    end
  end

  // execute stage results
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      res_r   <= 32'h0000_0000;
      zn_r    <= 1'b0;
      cn_r    <= 1'b0;
      known_r <= 1'b0;
    end
    else if (st_r == S_EXEC)
    begin
      res_r   <= alu_bus.result;
      zn_r    <= alu_bus.z_out;
      cn_r    <= alu_bus.c_out;
      known_r <= alu_bus.known && exec_ok;
    end
  end

  // flags
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      z_r <= corca_pkg::FLAG_RST;
      c_r <= corca_pkg::FLAG_RST;
    end
    else if (run_r && !launch_w && st_r == S_WRITE && known_r)
    begin
      if (ir_r[corca_pkg::ZEFF_BIT])
        z_r <= zn_r; // [RQ2] [RQ6] [RQ9]
      if (ir_r[corca_pkg::CEFF_BIT])
        c_r <= cn_r; // [RQ2] [RQ8] [RQ11]
    end
  end

  // ram: core write back, bus writes only while halted
  always_ff @(posedge CLK_SYS)
  begin
    if (run_r && !launch_w && st_r == S_WRITE && known_r && ir_r[corca_pkg::WR_BIT]
        && dst_f < 9'(corca_pkg::RAM_DEPTH))
      ram[dst_f] <= res_r; // [RQ1] [RQ8] [RQ11]
    else if (bus_wr && ram_hit && !run_r)
      ram[bus_idx] <= (ram[bus_idx] & ~wmask) | (WB_DAT_I & wmask); // [RQ5]
  end

  // wishbone answer, ack in the second cycle of each request
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= bus_req && !ack_r;
      if (bus_req && !ack_r)
      begin
        if (ram_hit)
          rdat_r <= ram[bus_idx];
        else if (WB_ADR_I == corca_pkg::ADR_STATUS)
          rdat_r <= {29'h0000_0000, c_r, z_r, run_r};
        else if (WB_ADR_I == corca_pkg::ADR_PC)
          rdat_r <= {23'h00_0000, pc_r};
        else
          rdat_r <= 32'h0000_0000;
      end
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = rdat_r;

  // checks
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  launch_origin_a: assert property (launch_w |=> pc_r == 9'h000 && st_r == S_FETCH && run_r) // [RQ4]
    else $error("launch did not start at ram address zero");
  first_fetch_a: assert property (launch_w ##1 (run_r && !launch_w) // [RQ4]
    |=> ir_r == $past(ram[corca_pkg::LAUNCH_ADDR]))
    else $error("first instruction not fetched from ram address zero");
  four_clock_a: assert property ((st_r == S_FETCH && run_r && !launch_w) ##1 (!launch_w)[*3] // [RQ1]
    |=> (st_r == S_FETCH && pc_r != $past(pc_r, 4)) || !run_r)
    else $error("instruction did not take four clocks");
  pc_range_a: assert property (pc_r < 9'(corca_pkg::RAM_DEPTH)) // [RQ5]
    else $error("program counter outside ram");
  imm_zext_a: assert property (st_r == S_OPER && run_r && !launch_w && ir_r[corca_pkg::IMM_BIT] // [RQ3]
    |=> s_r == {23'h00_0000, $past(src_f)})
    else $error("immediate operand not zero extended");
  or_result_a: assert property (st_r == S_EXEC && opc == corca_pkg::OPC_OR // [RQ1]
    |=> res_r == (d_r | s_r) && zn_r == (res_r == 32'h0000_0000))
    else $error("or result wrong");
  write_back_a: assert property (run_r && !launch_w && st_r == S_WRITE && known_r // [RQ1]
    && ir_r[corca_pkg::WR_BIT] && dst_f < 9'(corca_pkg::RAM_DEPTH) |=> ram[$past(dst_f)] == $past(res_r))
    else $error("result not written to destination");
  no_write_a: assert property (run_r && !launch_w && st_r == S_WRITE && !ir_r[corca_pkg::WR_BIT] // [RQ1]
    && dst_f < 9'(corca_pkg::RAM_DEPTH) |=> ram[$past(dst_f)] == $past(ram[dst_f]))
    else $error("destination changed although no-write was set");
  or_parity_a: assert property (run_r && st_r == S_WRITE && known_r && !launch_w && opc == corca_pkg::OPC_OR // [RQ2]
    && ir_r[corca_pkg::CEFF_BIT] |=> c_r == ^$past(res_r))
    else $error("or carry is not result parity");
  rcl_one_a: assert property (st_r == S_EXEC && opc == corca_pkg::OPC_RCL && s_r[4:0] == 5'h01 // [RQ6]
    |=> res_r == {$past(d_r[30:0]), $past(c_r)})
    else $error("left rotate by one wrong");
  rcr_one_a: assert property (st_r == S_EXEC && opc == corca_pkg::OPC_RCR && s_r[4:0] == 5'h01 // [RQ9]
    |=> res_r == {$past(c_r), $past(d_r[31:1])})
    else $error("right rotate by one wrong");
  rot_zero_a: assert property (run_r && !launch_w && st_r == S_WRITE && known_r && is_rot // [RQ6] [RQ9]
    && ir_r[corca_pkg::ZEFF_BIT] |=> z_r == ($past(res_r) == 32'h0000_0000))
    else $error("rotate zero flag wrong");
  rcl_carry_a: assert property (st_r == S_EXEC && !launch_w && opc == corca_pkg::OPC_RCL // [RQ8]
    ##1 run_r && !launch_w && known_r && ir_r[corca_pkg::CEFF_BIT] |=> c_r == $past(d_r[31], 2))
    else $error("left rotate carry not original bit 31");
  rcr_carry_a: assert property (st_r == S_EXEC && !launch_w && opc == corca_pkg::OPC_RCR // [RQ11]
    ##1 run_r && !launch_w && known_r && ir_r[corca_pkg::CEFF_BIT] |=> c_r == $past(d_r[0], 2))
    else $error("right rotate carry not original bit 0");
  rot_count_a: assert property (st_r == S_OPER && run_r && !launch_w && is_rot // [RQ13]
    |=> s_r[31:9] == 23'h00_0000 && (s_r[8:5] == 4'h0 || $past(ir_r[corca_pkg::IMM_BIT])))
    else $error("register rotate count not cut to five bits");

  launch_c: cover property (launch_w ##1 st_r == S_FETCH ##4 st_r == S_FETCH);
  no_write_c: cover property (run_r && st_r == S_WRITE && known_r && !ir_r[corca_pkg::WR_BIT]);
  or_run_c: cover property (st_r == S_EXEC && opc == corca_pkg::OPC_OR && exec_ok);
  rcl_run_c: cover property (st_r == S_EXEC && opc == corca_pkg::OPC_RCL && s_r[4:0] == 5'h1F);
  rcr_run_c: cover property (st_r == S_EXEC && opc == corca_pkg::OPC_RCR && c_r);
endmodule
`default_nettype wire

//--- testbench/corca_top_bench.sv
// self-checking bench for the or / rotate-through-carry core slice
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) check(n, e, g)
module corca_top_bench;
  localparam logic [5:0] OPS [3] = '{corca_pkg::OPC_OR, corca_pkg::OPC_RCL, corca_pkg::OPC_RCR};
  logic        clk_sys;
  logic        reset_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] dat_w;
  logic [31:0] dat_r;
  logic        ack;
  logic [31:0] seed;
  logic        z_m;
  logic        c_m;
  int          n_mismatch;
  int          samples_checked;

  corca_top dut
  (
    .CLK_SYS  (clk_sys),
    .RESET_N  (reset_n),
    .WB_CYC_I (cyc),
    .WB_STB_I (stb),
    .WB_WE_I  (we),
    .WB_ADR_I (adr),
    .WB_SEL_I (sel),
    .WB_DAT_I (dat_w),
    .WB_DAT_O (dat_r),
    .WB_ACK_O (ack)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // returns {zero, carry, result}
  function automatic logic [33:0] model(input logic [5:0] op, input logic [31:0] d, input logic [31:0] s,
                                        input logic c);
    logic [31:0] r;
    logic        co;
    r  = d;
    co = d[0];
    if (op == corca_pkg::OPC_OR)
    begin
      r  = d | s;
      co = ^r;
    end
    else if (op == corca_pkg::OPC_RCL)
    begin
      co = d[31];
      repeat (s[4:0]) r = {r[30:0], c};
    end
    else
    begin
      repeat (s[4:0]) r = {c, r[31:1]};
    end
    return {r == 32'h0, co, r};
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk_sys);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_w <= d;
    sel   <= 4'hF;
    i = 0;
    do
    begin
      @(posedge clk_sys);
      i++;
    end
    while (ack !== 1'b1 && i < 16);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  // fx is {zero effect, carry effect, write result, immediate}
  task automatic run_one(input logic [5:0] op, input logic [3:0] fx, input logic [3:0] cond,
                         input logic [31:0] dv, input logic [31:0] sv);
    logic [8:0]  da;
    logic [8:0]  sa;
    logic [31:0] src;
    logic [31:0] q;
    logic [33:0] m;
    logic        ex;
    int          i;
    da  = 9'h008 + 9'(rnd() % 240);
    sa  = 9'h100 + 9'(rnd() % 240);
    src = fx[0] ? {23'h0, sv[8:0]} : sv;
    wr({1'b0, da, 2'b00}, dv);
    wr({1'b0, sa, 2'b00}, sv);
    wr(12'h000, {op, fx, cond, da, fx[0] ? sv[8:0] : sa});
    wr(corca_pkg::ADR_CTRL, 32'h1);
    wr(corca_pkg::ADR_CTRL, 32'h2);
    i = 0;
    q = 32'h1;
    while (q[corca_pkg::STAT_RUN] !== 1'b0 && i < 20)
    begin
      wb(1'b0, corca_pkg::ADR_STATUS, 32'h0, q);
      i++;
    end
    if (q[corca_pkg::STAT_RUN] !== 1'b0)
    begin
      n_mismatch++;
      report_and_stop();
    end
    m  = model(op, dv, src, c_m);
    ex = cond[{c_m, z_m}];
    z_m = (ex && fx[3]) ? m[33] : z_m;
    c_m = (ex && fx[2]) ? m[32] : c_m;
    `CHK("flags", {29'h0, c_m, z_m, 1'b0}, {29'h0, q[2:0]});
    wb(1'b0, corca_pkg::ADR_PC, 32'h0, q);
    `CHK("pc", 32'(corca_pkg::LAUNCH_ADDR) + 32'h1, q);
    wb(1'b0, {1'b0, da, 2'b00}, 32'h0, q);
    `CHK("dest", (ex && fx[1]) ? m[31:0] : dv, q);
  endtask

  initial
  begin
    logic [31:0] q;
    reset_n         = 1'b0;
    cyc             = 1'b0;
    stb             = 1'b0;
    we              = 1'b0;
    adr             = 12'h000;
    sel             = 4'hF;
    dat_w           = 32'h0;
    seed            = 32'hD9DD;
    z_m             = 1'b0;
    c_m             = 1'b0;
    n_mismatch      = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    // words after the launch word stay inert
    for (int a = 1; a < 8; a++)
    begin
      wr(12'(a * 4), 32'h0);
    end
    wr(12'h7BC, 32'hA5C30F96);
    wb(1'b0, 12'h7BC, 32'h0, q);
    `CHK("ram top word", 32'hA5C30F96, q);
    wb(1'b0, 12'h7C0, 32'h0, q);
    `CHK("ram past end", 32'h0, q);
    // corners: zero result, full immediate, counts 0 and 31, masked count, never
    run_one(corca_pkg::OPC_OR, 4'b1110, 4'hF, 32'h0, 32'h0);
    run_one(corca_pkg::OPC_OR, 4'b0111, 4'hF, 32'h0, 32'hFFFFFFFF);
    run_one(corca_pkg::OPC_RCL, 4'b1110, 4'hF, 32'h80000001, 32'h0);
    run_one(corca_pkg::OPC_RCL, 4'b1111, 4'hF, 32'h12345678, 32'h1F);
    run_one(corca_pkg::OPC_RCL, 4'b1110, 4'hF, 32'hC0000001, 32'h1);
    run_one(corca_pkg::OPC_RCR, 4'b1100, 4'hF, 32'h00000001, 32'hFFFFFFE3);
    run_one(corca_pkg::OPC_RCR, 4'b1110, 4'hF, 32'h00000001, 32'h00000001);
    run_one(corca_pkg::OPC_RCR, 4'b1110, 4'h0, 32'h0F0F0F0F, 32'h4);
    repeat (80)
    begin
      run_one(OPS[rnd() % 3], 4'(rnd()), (rnd() % 2 == 0) ? 4'hF : 4'(rnd()), rnd(), rnd());
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
